// File: common/oorfs_pkg.sv
// Constants and types for the output turn-off ramp and fault status slice
package oorfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Paging and command codes
  localparam int        NPAGE      = 2;
  localparam logic [7:0] CMD_FALL  = 8'h65;
  localparam logic [7:0] CMD_SBYTE = 8'h78;
  localparam logic [7:0] CMD_SWORD = 8'h79;
  localparam logic [7:0] CMD_SVOUT = 8'h7a;

  // Reset values
  localparam logic [15:0] FALL_RST = 16'hca80;
  localparam logic [15:0] ZERO16   = 16'h0000;

  // Linear-11 field layout
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one ramp tick is 1/16 ms
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_LOG2     = 4;
  localparam int TICK_NS       = 1000000 / (1 << TICK_LOG2);
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int MAX_FALL_MS   = 100;
  localparam int MAX_TICKS     = MAX_FALL_MS << TICK_LOG2;
  localparam int MIN_FALL_US   = 500;

  ////////////////////////////////////////////////////////////////////////////
  // Summary word bit positions
  localparam int SW_VOUT  = 15;
  localparam int SW_IOUT  = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_VEND  = 12;
  localparam int SW_PGOOD = 11;
  localparam int SW_OTHER = 9;
  localparam int SW_UNKN  = 8;
  localparam int SW_BUSY  = 7;
  localparam int SW_OFF   = 6;
  localparam int SW_OVF   = 5;
  localparam int SW_OCF   = 4;
  localparam int SW_VINUV = 3;
  localparam int SW_TEMP  = 2;
  localparam int SW_CML   = 1;
  localparam int SW_NONE  = 0;

  // Output voltage status byte bit positions
  localparam int VO_OVF = 7;
  localparam int VO_OVW = 6;
  localparam int VO_UVW = 5;
  localparam int VO_UVF = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [10:0] oorfs_tick_t;

  typedef enum logic [1:0] {
    SEQ_RUN  = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_FALL = 2'b10,
    SEQ_OFF  = 2'b11
  } oorfs_seq_e;

  // Fault and warning events, also the sticky detail bits
  typedef struct packed {
    logic out_overvoltage_fault;
    logic out_overvoltage_warning;
    logic out_undervoltage_warning;
    logic out_undervoltage_fault;
    logic out_overcurrent_fault;
    logic iout_other;
    logic in_undervoltage_fault;
    logic input_other;
    logic vendor_fault_summary;
    logic temperature;
    logic comms_logic_memory_flag;
    logic busy;
    logic unknown;
  } oorfs_evt_s;

  // Live levels per page
  typedef struct packed {
    logic enable;
    logic power_not_good;
    logic misc_set;
  } oorfs_lvl_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        page;
    logic [7:0]  code;
    logic [15:0] data;
  } oorfs_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } oorfs_rsp_s;

  typedef struct packed {
    logic [NPAGE-1:0][15:0] word;
    logic [15:0]            rda;
    logic [15:0]            rdb;
  } oorfs_mem_s;

endpackage : oorfs_pkg

// File: rtl/oorfs_ramp_mem.sv
// Paged storage for the output ramp-down time, two registered read ports
`timescale 1ns/100ps
`default_nettype none
module oorfs_ramp_mem (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        wr_en_in,
  input  wire logic        wr_page_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        rda_page_in,
  input  wire logic        rdb_page_in,
  output logic      [15:0] rda_data_out,
  output logic      [15:0] rdb_data_out
);

  oorfs_pkg::oorfs_mem_s s_q;
  oorfs_pkg::oorfs_mem_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Read, then write; a same-cycle read sees the old word
  always_comb begin
    s_d     = s_q;
    s_d.rda = s_q.word[rda_page_in];
    s_d.rdb = s_q.word[rdb_page_in];
    if (wr_en_in) begin
      s_d.word[wr_page_in] = wr_data_in;
    end
  end

  // Every page wakes at its 5 ms default
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q.word <= {oorfs_pkg::NPAGE{oorfs_pkg::FALL_RST}};
      s_q.rda  <= oorfs_pkg::ZERO16;
      s_q.rdb  <= oorfs_pkg::ZERO16;
    end else begin
      s_q <= s_d;
    end
  end

  assign rda_data_out = s_q.rda;
  assign rdb_data_out = s_q.rdb;

endmodule : oorfs_ramp_mem
`default_nettype wire

// File: rtl/oorfs_top.sv
// Output turn-off ramp and fault status command slice, paged per output
//
// What this block does
// - Ramp-down time is a paged 16-bit linear value, Y times two to N ms.
// - Ramp-down time resets to CA80h (5 ms), read/write, write protectable.
// - Ramp-down times from 0 to 100 ms are accepted.
// - On disable, wait the turn-off delay, then ramp down over ramp time.
// - Fault summary word is paged, read-only, latched bits reset to zero, writes refused.
// - Summary low byte and byte-wide summary share storage and read alike.
// - Summary bit 15 flags any output voltage fault or warning.
// - Summary bit 14 flags any output current or power fault or warning.
// - Summary bit 13 flags any input voltage, current or power event.
// - Bit 12 flags vendor events; bit 9 flags any misc status bit.
// - Summary bit 11 set while power is reported not good.
// - Summary bit 8 flags a fault type not covered by bits 15 to 1.
// - Summary bit 7 flags a fault declared because the device was busy.
// - Summary bit 6 set whenever output delivers no power, for any cause.
// - Bits 5, 4, 3 flag output OV, output OC and input UV faults.
// - Bit 2 flags temperature events; bit 1 comms, memory or logic faults.
// - Bit 0 flags any event not represented by bits 7 to 1.
// - Output voltage byte is paged, read-only, resets zero; bits 7, 6 OV.
// - Output voltage byte bit 5 UV warning, bit 4 UV fault, 3:0 zero.
//
// Times resolve to 1/16 ms and truncate. A wait may last up to one tick
// longer than set, since the divider runs free; a ramp always lasts one tick longer.
// Nothing enforces the recommended 0.5 ms minimum.
`timescale 1ns/100ps
`default_nettype none
module oorfs_top (
  input  wire logic                                    clk_in,
  input  wire logic                                    srst_in,
  input  wire oorfs_pkg::oorfs_cmd_s                   cmd_in,
  input  wire logic                                    write_protect_in,
  input  wire logic                                    clear_faults_in,
  input  wire oorfs_pkg::oorfs_evt_s [oorfs_pkg::NPAGE-1:0] evt_in,
  input  wire oorfs_pkg::oorfs_lvl_s [oorfs_pkg::NPAGE-1:0] lvl_in,
  input  wire logic [oorfs_pkg::NPAGE-1:0][15:0]       turn_off_wait_in,
  output oorfs_pkg::oorfs_rsp_s                        rsp_out,
  output logic [oorfs_pkg::NPAGE-1:0]                  output_on_out,
  output logic [oorfs_pkg::NPAGE-1:0]                  fall_active_out,
  output oorfs_pkg::oorfs_tick_t [oorfs_pkg::NPAGE-1:0] ticks_left_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block in one record
  typedef struct packed {
    oorfs_pkg::oorfs_seq_e  [oorfs_pkg::NPAGE-1:0] seq;
    oorfs_pkg::oorfs_tick_t [oorfs_pkg::NPAGE-1:0] cnt;
    oorfs_pkg::oorfs_tick_t [oorfs_pkg::NPAGE-1:0] fall;
    oorfs_pkg::oorfs_evt_s  [oorfs_pkg::NPAGE-1:0] stk;
    logic [10:0]                                   div;
    logic                                          scan;
    logic                                          scan_d1;
    logic                                          pend;
    logic                                          pend_err;
    logic                                          pend_wr;
    logic                                          pend_page;
    logic [7:0]                                    pend_code;
    oorfs_pkg::oorfs_rsp_s                         rsp;
  } oorfs_state_s;

  oorfs_state_s s_q;
  oorfs_state_s s_d;

  logic [15:0] mem_rda;
  logic [15:0] mem_rdb;
  logic        fall_wr;
  logic        tick;
  logic        rd_off;
  logic [15:0] rd_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Linear value to ramp ticks, clamped to the accepted range
  function automatic oorfs_pkg::oorfs_tick_t lin_to_ticks(input logic [15:0] v);
    int n;
    int y;
    int sh;
    int t;
    n  = int'($signed(v[oorfs_pkg::EXP_MSB:oorfs_pkg::EXP_LSB]));
    y  = int'($signed(v[oorfs_pkg::MAN_MSB:0]));
    // Ticks are Y times 2^(N+4); a right shift truncates
    sh = n + oorfs_pkg::TICK_LOG2;

    // A negative time reads as zero
    if (y < 0) begin
      t = 0;
    end else if (sh >= 0) begin
      t = y << sh;
    end else begin
      t = y >> (-sh);
    end
    // Large exponents would overflow long before the clamp, so cap early
    if (sh > 20 || t > oorfs_pkg::MAX_TICKS) begin
      t = oorfs_pkg::MAX_TICKS;
    end

    // Same conversion serves the turn-off wait
    return oorfs_pkg::oorfs_tick_t'(t);
  endfunction : lin_to_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Summary word built live from sticky details and present levels
  function automatic logic [15:0] summary(input oorfs_pkg::oorfs_evt_s e,
                                          input oorfs_pkg::oorfs_lvl_s l,
                                          input logic off);
    logic [15:0] w;
    w = oorfs_pkg::ZERO16;
    w[oorfs_pkg::SW_VOUT]  = e.out_overvoltage_fault | e.out_overvoltage_warning
                           | e.out_undervoltage_warning
                           | e.out_undervoltage_fault;
    w[oorfs_pkg::SW_IOUT]  = e.out_overcurrent_fault | e.iout_other;
    w[oorfs_pkg::SW_INPUT] = e.in_undervoltage_fault | e.input_other;
    w[oorfs_pkg::SW_VEND]  = e.vendor_fault_summary;
    // Power good and misc are live levels, never latched
    w[oorfs_pkg::SW_PGOOD] = l.power_not_good;
    w[oorfs_pkg::SW_OTHER] = l.misc_set;
    w[oorfs_pkg::SW_UNKN]  = e.unknown;
    w[oorfs_pkg::SW_BUSY]  = e.busy;
    w[oorfs_pkg::SW_OFF]   = off;
    w[oorfs_pkg::SW_OVF]   = e.out_overvoltage_fault;
    w[oorfs_pkg::SW_OCF]   = e.out_overcurrent_fault;
    w[oorfs_pkg::SW_VINUV] = e.in_undervoltage_fault;
    w[oorfs_pkg::SW_TEMP]  = e.temperature;
    w[oorfs_pkg::SW_CML]   = e.comms_logic_memory_flag;
    // Events that none of bits 7:1 can carry
    w[oorfs_pkg::SW_NONE]  = e.out_overvoltage_warning
                           | e.out_undervoltage_warning
                           | e.out_undervoltage_fault | e.iout_other
                           | e.input_other | e.vendor_fault_summary
                           | e.unknown | l.power_not_good
                           | l.misc_set;
    return w;
  endfunction : summary

  ////////////////////////////////////////////////////////////////////////////
  // Output voltage status byte, low nibble always zero
  // Only four voltage detail bits exist behind it
  function automatic logic [7:0] vout_byte(input oorfs_pkg::oorfs_evt_s e);
    logic [7:0] b;
    b = 8'h00;
    b[oorfs_pkg::VO_OVF] = e.out_overvoltage_fault;
    b[oorfs_pkg::VO_OVW] = e.out_overvoltage_warning;
    b[oorfs_pkg::VO_UVW] = e.out_undervoltage_warning;
    b[oorfs_pkg::VO_UVF] = e.out_undervoltage_fault;
    return b;
  endfunction : vout_byte

  // A page delivers power only while its sequencer sits in RUN
  function automatic logic page_off(input oorfs_pkg::oorfs_seq_e q);
    return (q != oorfs_pkg::SEQ_RUN);
  endfunction : page_off

  ////////////////////////////////////////////////////////////////////////////
  // Only the ramp time is writable, and only while unprotected
  // A refused write must leave storage untouched
  assign fall_wr = cmd_in.valid & cmd_in.write
                 & (cmd_in.code == oorfs_pkg::CMD_FALL)
                 & ~write_protect_in;

  // Port a answers the host; port b feeds the ramp shadows
  oorfs_ramp_mem u_mem (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .wr_en_in     (fall_wr),
    .wr_page_in   (cmd_in.page),
    .wr_data_in   (cmd_in.data),
    .rda_page_in  (cmd_in.page),
    .rdb_page_in  (s_q.scan),
    .rda_data_out (mem_rda),
    .rdb_data_out (mem_rdb)
  );

  // Tick enable every 1/16 ms
  // Free running, so the first tick of a wait comes early
  assign tick = (s_q.div == 11'(oorfs_pkg::TICK_CYC - 1));

  // One summary copy feeds the word and its low byte, so they cannot differ
  always_comb begin
    rd_off = page_off(s_q.seq[s_q.pend_page]);
    rd_sum = summary(s_q.stk[s_q.pend_page], lvl_in[s_q.pend_page], rd_off);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;

    // Ramp tick divider
    s_d.div = tick ? 11'h000 : s_q.div + 11'h001;

    // Scan pages so each shadow ramp time is at most three cycles stale
    // Both pages share one read port, taking turns
    s_d.scan    = ~s_q.scan;
    s_d.scan_d1 = s_q.scan;
    s_d.fall[s_q.scan_d1] = lin_to_ticks(mem_rdb);

    // Sticky details: a new event beats a clear in the same cycle
    // Clear is global and empties every page at once
    for (int p = 0; p < oorfs_pkg::NPAGE; p++) begin
      s_d.stk[p] = (clear_faults_in ? '0 : s_q.stk[p]) | evt_in[p];
    end

    // Turn-off sequencer per page
    for (int p = 0; p < oorfs_pkg::NPAGE; p++) begin
      case (s_q.seq[p])
        // Disable is sampled every cycle; the wait starts next edge
        oorfs_pkg::SEQ_RUN: begin
          if (!lvl_in[p].enable) begin
            s_d.seq[p] = oorfs_pkg::SEQ_WAIT;
            s_d.cnt[p] = lin_to_ticks(turn_off_wait_in[p]);
          end
        end

        oorfs_pkg::SEQ_WAIT: begin
          // Re-enable during the delay aborts the shutdown
          if (lvl_in[p].enable) begin
            s_d.seq[p] = oorfs_pkg::SEQ_RUN;
          end else if (tick) begin
            if (s_q.cnt[p] == '0) begin
              s_d.seq[p] = oorfs_pkg::SEQ_FALL;
              s_d.cnt[p] = s_q.fall[p];
            end else begin
              s_d.cnt[p] = s_q.cnt[p] - 11'h001;
            end
          end
        end

        oorfs_pkg::SEQ_FALL: begin
          // The ramp runs to the end once started
          if (tick) begin
            if (s_q.cnt[p] == '0) begin
              s_d.seq[p] = oorfs_pkg::SEQ_OFF;
            end else begin
              s_d.cnt[p] = s_q.cnt[p] - 11'h001;
            end
          end
        end

        // Reset lands here; an enabled page runs next edge
        oorfs_pkg::SEQ_OFF: begin
          if (lvl_in[p].enable) begin
            s_d.seq[p] = oorfs_pkg::SEQ_RUN;
            s_d.cnt[p] = '0;
          end
        end

        default: begin
          s_d.seq[p] = oorfs_pkg::SEQ_OFF;
        end
      endcase
    end

    // Command stage: note what was asked and whether it is refused
    s_d.pend      = cmd_in.valid;
    s_d.pend_wr   = cmd_in.write;
    s_d.pend_page = cmd_in.page;
    s_d.pend_code = cmd_in.code;
    s_d.pend_err  = 1'b0;
    if (cmd_in.valid) begin
      case (cmd_in.code)
        oorfs_pkg::CMD_FALL: begin
          s_d.pend_err = cmd_in.write & write_protect_in;
        end
        oorfs_pkg::CMD_SBYTE,
        oorfs_pkg::CMD_SWORD,
        oorfs_pkg::CMD_SVOUT: begin
          s_d.pend_err = cmd_in.write;
        end
        // Unknown codes are refused
        default: begin
          s_d.pend_err = 1'b1;
        end
      endcase
    end

    // Answer stage: registered so the data pins come from flops
    s_d.rsp.valid = s_q.pend;
    s_d.rsp.err   = s_q.pend_err;
    s_d.rsp.data  = oorfs_pkg::ZERO16;
    // Writes and refusals answer with zero data
    if (s_q.pend && !s_q.pend_wr && !s_q.pend_err) begin
      case (s_q.pend_code)
        oorfs_pkg::CMD_FALL: begin
          s_d.rsp.data = mem_rda;
        end
        oorfs_pkg::CMD_SWORD: begin
          s_d.rsp.data = rd_sum;
        end
        oorfs_pkg::CMD_SBYTE: begin
          // Same bits as the low half of the word
          s_d.rsp.data = {8'h00, rd_sum[7:0]};
        end
        oorfs_pkg::CMD_SVOUT: begin
          s_d.rsp.data = {8'h00, vout_byte(s_q.stk[s_q.pend_page])};
        end
        default: begin
          s_d.rsp.data = oorfs_pkg::ZERO16;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves every page off and fault free
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int p = 0; p < oorfs_pkg::NPAGE; p++) begin
        s_q.seq[p]  <= oorfs_pkg::SEQ_OFF;
      end
      s_q.cnt       <= '0;
      // Ramp shadows refill from storage within three cycles
      s_q.fall      <= '0;
      s_q.stk       <= '0;
      s_q.div       <= 11'h000;
      s_q.scan      <= 1'b0;
      s_q.scan_d1   <= 1'b0;
      s_q.pend      <= 1'b0;
      s_q.pend_err  <= 1'b0;
      s_q.pend_wr   <= 1'b0;
      s_q.pend_page <= 1'b0;
      s_q.pend_code <= 8'h00;
      s_q.rsp       <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state record
  // Ticks left shows whichever phase is counting
  always_comb begin
    for (int p = 0; p < oorfs_pkg::NPAGE; p++) begin
      output_on_out[p]   = ~page_off(s_q.seq[p]);
      fall_active_out[p] = (s_q.seq[p] == oorfs_pkg::SEQ_FALL);
      ticks_left_out[p]  = s_q.cnt[p];
    end
  end

  assign rsp_out = s_q.rsp;

endmodule : oorfs_top
`default_nettype wire

// File: test/oorfs_top_asserts.sv
// Port-level checks for the ramp time and fault status slice
`timescale 1ns/100ps
`default_nettype none
module oorfs_top_asserts (
  input wire logic                                       clk_in,
  input wire logic                                       srst_in,
  input wire oorfs_pkg::oorfs_cmd_s                      cmd_in,
  input wire logic                                       write_protect_in,
  input wire oorfs_pkg::oorfs_lvl_s [oorfs_pkg::NPAGE-1:0] lvl_in,
  input wire oorfs_pkg::oorfs_rsp_s                      rsp_out,
  input wire logic [oorfs_pkg::NPAGE-1:0]                output_on_out,
  input wire logic [oorfs_pkg::NPAGE-1:0]                fall_active_out,
  input wire oorfs_pkg::oorfs_tick_t [oorfs_pkg::NPAGE-1:0] ticks_left_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  logic rd_c;
  logic wr_c;
  logic pg_q;
  logic ng_q;
  logic off_q;
  // Command qualifiers
  assign rd_c = cmd_in.valid & ~cmd_in.write;
  assign wr_c = cmd_in.valid & cmd_in.write;
  // Page levels as seen on the edge where the summary is composed
  always_ff @(posedge clk_in) begin
    pg_q  <= cmd_in.page;
    ng_q  <= lvl_in[pg_q].power_not_good;
    off_q <= ~output_on_out[pg_q];
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_STAT_RO:
    assert property (wr_c && cmd_in.code inside {8'h78, 8'h79, 8'h7a}
      |-> ##2 rsp_out.valid && rsp_out.err && rsp_out.data == 16'h0000)
      else $error("status write not refused");
  AST_WP_REFUSED:
    assert property (wr_c && cmd_in.code == 8'h65 && write_protect_in
      |-> ##2 rsp_out.valid && rsp_out.err)
      else $error("protected ramp write accepted");
  AST_FALL_WR_OK:
    assert property (wr_c && cmd_in.code == 8'h65 && !write_protect_in
      |-> ##2 rsp_out.valid && !rsp_out.err)
      else $error("ramp write refused");
  AST_VOUT_UNUSED:
    assert property (rd_c && cmd_in.code == 8'h7a
      |-> ##2 rsp_out.valid && rsp_out.data[15:8] == 8'h00 && rsp_out.data[3:0] == 4'h0)
      else $error("unused voltage status bits set");
  AST_BYTE_HIGH:
    assert property (rd_c && cmd_in.code == 8'h78
      |-> ##2 rsp_out.valid && !rsp_out.err && rsp_out.data[15:8] == 8'h00)
      else $error("byte summary upper bits set");
  AST_PGOOD_BIT:
    assert property (rd_c && cmd_in.code == 8'h79 |-> ##2 rsp_out.data[11] == ng_q)
      else $error("power not good bit wrong");
  AST_OFF_BIT:
    assert property (rd_c && cmd_in.code == 8'h79 |-> ##2 rsp_out.data[6] == off_q)
      else $error("off bit wrong");
  AST_WAIT_FIRST:
    assert property ($fell(output_on_out[0]) |-> !fall_active_out[0] [*2])
      else $error("ramp began without turn-off wait");
  AST_FALL_AFTER_OFF:
    assert property ($rose(fall_active_out[0]) |-> !$past(output_on_out[0]) && !output_on_out[0])
      else $error("ramp began while output on");
  AST_TICK_CAP:
    assert property (ticks_left_out[0] <= 11'h640 && ticks_left_out[1] <= 11'h640)
      else $error("tick count above 100 ms");
endmodule : oorfs_top_asserts
bind oorfs_top oorfs_top_asserts u_chk (
  .clk_in,
  .srst_in,
  .cmd_in,
  .write_protect_in,
  .lvl_in,
  .rsp_out,
  .output_on_out,
  .fall_active_out,
  .ticks_left_out
);
`default_nettype wire

// File: test/oorfs_host_model.sv
// Host side of the command port: one command, bounded wait for its answer
`timescale 1ns/100ps
`default_nettype none
module oorfs_host_model (
  input  wire logic                  clk_in,
  input  wire oorfs_pkg::oorfs_rsp_s rsp_in,
  output oorfs_pkg::oorfs_cmd_s      cmd_out
);
  initial cmd_out = '0;
  // Valid is a single-cycle pulse; idle fields show inverted junk, not old data
  task automatic xfer(input logic w, input logic pg, input logic [7:0] c,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic er, output bit ok);
    ok = 1'b0;
    rd = 16'hffff;
    er = 1'b1;
    @(posedge clk_in);
    cmd_out <= '{1'b1, w, pg, c, wd};
    @(posedge clk_in);
    cmd_out <= '{1'b0, ~w, ~pg, ~c, ~wd};
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk_in);
      if (rsp_in.valid === 1'b1) begin
        ok = 1'b1;
        rd = rsp_in.data;
        er = rsp_in.err;
      end
    end
  endtask : xfer
endmodule : oorfs_host_model
`default_nettype wire

// File: test/output_off_ramp_and_fault_status_bench.sv
// Self-checking bench for the turn-off ramp and fault status slice
`timescale 1ns/100ps
`default_nettype none
module output_off_ramp_and_fault_status_bench;
  logic                         clk_in;
  logic                         srst_in;
  logic                         wp;
  logic                         clr;
  oorfs_pkg::oorfs_cmd_s        cmd;
  oorfs_pkg::oorfs_rsp_s        rsp;
  oorfs_pkg::oorfs_evt_s [1:0]  evt;
  oorfs_pkg::oorfs_lvl_s [1:0]  lvl;
  logic [1:0][15:0]             tow;
  logic [1:0]                   on;
  logic [1:0]                   fall;
  oorfs_pkg::oorfs_tick_t [1:0] tl;
  logic [1:0][15:0]             ramp;
  oorfs_pkg::oorfs_evt_s        ev;
  oorfs_pkg::oorfs_lvl_s        lv;
  logic [15:0]                  d;
  logic [15:0]                  r;
  logic                         p;
  int                           err_count;
  int                           comparisons;
  int                           seed;
  int                           n;
  ////////////////////////////////////////////////////////////////////////////
  oorfs_top u_dut (.clk_in(clk_in), .srst_in(srst_in), .cmd_in(cmd),
    .write_protect_in(wp), .clear_faults_in(clr), .evt_in(evt), .lvl_in(lvl),
    .turn_off_wait_in(tow), .rsp_out(rsp), .output_on_out(on),
    .fall_active_out(fall), .ticks_left_out(tl));
  oorfs_host_model u_host (.clk_in(clk_in), .rsp_in(rsp), .cmd_out(cmd));
  // Clock, 50 ns period
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Summary word expected from sticky events, live levels and off state
  function automatic logic [15:0] sum_exp(input logic [12:0] x, input logic [2:0] l,
                                          input logic off);
    sum_exp = {|x[12:9], |x[8:7], |x[6:5], x[4], l[1], 1'b0, l[0], x[0], x[1], off,
               x[12], x[8], x[6], x[3], x[2], |{x[11:9], x[7], x[5:4], x[0], l[1:0]}};
  endfunction : sum_exp
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic test_done();
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // One access; a missing answer ends the run
  task automatic acc(input logic w, input logic pg, input logic [7:0] c,
                     input logic [15:0] wd, input logic xe, output logic [15:0] rd);
    logic er;
    bit   k;
    u_host.xfer(w, pg, c, wd, rd, er, k);
    if (!k) begin
      err_count++;
      test_done();
    end
    chk("err", {15'h0, xe}, {15'h0, er});
    if (w || xe)
      chk("wr_data", 16'h0000, rd);
  endtask : acc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h227082ad;
    err_count = 0;
    comparisons = 0;
    srst_in = 1'b1;
    wp = 1'b0;
    clr = 1'b0;
    evt = '0;
    tow = '0;
    lvl = 6'b100100;
    ramp = {2{16'hca80}};
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    // Reset contents of both pages
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, i[0], 8'h65, 16'h0000, 1'b0, r);
      chk("ramp_rst", 16'hca80, r);
      acc(1'b0, i[0], 8'h79, 16'h0000, 1'b0, r);
      chk("word_rst", 16'h0000, r);
      acc(1'b0, i[0], 8'h7a, 16'h0000, 1'b0, r);
      chk("vout_rst", 16'h0000, r);
    end
    // Ramp writes, boundaries first; protection and read-only codes refuse
    for (int i = 0; i < 12; i++) begin
      p = 1'($random(seed));
      d = {7'b1110001, 9'($random(seed))};
      if (i == 0)
        d = 16'h0064;
      if (i == 1)
        d = 16'he000;
      @(posedge clk_in);
      wp <= (i % 3 == 2);
      acc(1'b1, p, 8'h65, d, i % 3 == 2, r);
      if (i % 3 != 2)
        ramp[p] = d;
      acc(1'b1, p, 8'h78 + 8'(i % 3), d, 1'b1, r);
      acc(1'b0, p, 8'h65, 16'h0000, 1'b0, r);
      chk("ramp", ramp[p], r);
      acc(1'b0, ~p, 8'h65, 16'h0000, 1'b0, r);
      chk("ramp_other", ramp[~p], r);
    end
    @(posedge clk_in);
    wp <= 1'b0;
    // Each event alone, set together with a clear so set must win
    for (int b = 0; b < 13; b++) begin
      p = 1'($random(seed));
      ev = 13'h0001 << b;
      lv = {1'b1, 2'($random(seed))};
      @(posedge clk_in);
      evt[p] <= ev;
      lvl[p] <= lv;
      clr <= 1'b1;
      @(posedge clk_in);
      evt <= '0;
      clr <= 1'b0;
      d = sum_exp(ev, lv, 1'b0);
      acc(1'b0, p, 8'h79, 16'h0000, 1'b0, r);
      chk("word", d, r);
      acc(1'b0, p, 8'h78, 16'h0000, 1'b0, r);
      chk("byte", {8'h00, d[7:0]}, r);
      acc(1'b0, p, 8'h7a, 16'h0000, 1'b0, r);
      chk("vout", {8'h00, ev[12:9], 4'h0}, r);
      acc(1'b0, ~p, 8'h79, 16'h0000, 1'b0, r);
      chk("word_other", sum_exp('0, lvl[~p], 1'b0), r);
    end
    // Empty what the last event left, so page 0 reads clean
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    // Shutdown on page 0: one wait tick, then a two tick ramp
    acc(1'b1, 1'b0, 8'h65, 16'he002, 1'b0, r);
    @(posedge clk_in);
    tow[0] <= 16'he001;
    lvl[0] <= 3'b000;
    for (n = 0; n < 4000 && fall[0] !== 1'b1; n++) @(negedge clk_in);
    chk("wait_len", 16'h0001, {15'h0, n >= 1250 && n <= 2510});
    if (n >= 4000)
      test_done();
    chk("ramp_ticks", 16'h0002, {5'h00, tl[0]});
    for (n = 0; n < 4000 && fall[0] === 1'b1; n++) @(negedge clk_in);
    chk("fall_len", 16'h0001, {15'h0, n >= 2500 && n <= 3760});
    acc(1'b0, 1'b0, 8'h79, 16'h0000, 1'b0, r);
    chk("off", sum_exp('0, 3'b000, 1'b1), r);
    // Page 1 ramps at the 100 ms ceiling while page 0 comes back on
    acc(1'b1, 1'b1, 8'h65, 16'h0064, 1'b0, r);
    @(posedge clk_in);
    tow[1] <= 16'h0000;
    lvl <= 6'b000100;
    repeat (4) @(posedge clk_in);
    acc(1'b0, 1'b0, 8'h79, 16'h0000, 1'b0, r);
    chk("on_again", sum_exp('0, 3'b100, 1'b0), r);
    for (n = 0; n < 3000 && fall[1] !== 1'b1; n++) @(negedge clk_in);
    chk("max_ticks", 16'h0640, {5'h00, tl[1]});
    if (n >= 3000)
      err_count++;
    test_done();
  end
endmodule : output_off_ramp_and_fault_status_bench
`default_nettype wire
